// ### verilog/sivc_core.sv
// Interrupt control and two-variable calculation command interpreter
`timescale 1ns/1ns
`default_nettype none
`include "sivc_map.svh"

module sivc_core #(
    parameter int         NUM_IRQ     = 8,
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] HOST_ADDR   = 8'h02
) (
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    // Host command bytes
    input  wire logic [7:0]           rx_data,
    input  wire logic                 rx_valid,
    output logic                      rx_ready,
    // Reply bytes
    output logic      [7:0]           tx_data,
    output logic                      tx_valid,
    input  wire logic                 tx_ready,
    // Stored program instructions
    input  wire logic                 prog_valid,
    input  wire logic [7:0]           prog_op,
    input  wire logic [7:0]           prog_type,
    input  wire logic [7:0]           prog_bank,
    input  wire logic [31:0]          prog_value,
    output logic                      prog_ready,
    output logic                      prog_done,
    output logic      [7:0]           prog_status,
    // Interrupt sources and program context
    input  wire logic [NUM_IRQ-1:0]   irq_src,
    input  wire logic [31:0]          ctx_accu,
    input  wire logic [31:0]          ctx_x,
    input  wire logic [31:0]          ctx_pc,
    output logic                      irq_enter,
    output logic      [31:0]          irq_vector,
    output logic                      irq_return,
    output logic      [31:0]          ret_accu,
    output logic      [31:0]          ret_x,
    output logic      [31:0]          ret_pc,
    output logic      [2:0]           cond_flags,
    output logic                      irq_global_en,
    output logic                      in_handler
);
    import sivc_pkg::*;

    sivc_state_t         state_r;
    logic [3:0]          cnt_r;
    logic [7:0]          sum_r;
    logic [7:0]          addr_r;
    logic [7:0]          op_r;
    logic [7:0]          type_r;
    logic [7:0]          bank_r;
    logic [31:0]         value_r;
    logic                from_host_r;
    logic [7:0]          status_r;
    logic [3:0]          tx_idx_r;
    logic [7:0]          tx_sum_r;
    logic [31:0]         uvar_r [`SIVC_VAR_COUNT];
    logic [31:0]         vec_r  [NUM_IRQ];
    logic [NUM_IRQ-1:0]  irq_en_r;
    logic [NUM_IRQ-1:0]  pend_r;
    logic [31:0]         sv_accu_r;
    logic [31:0]         sv_x_r;
    logic [31:0]         sv_pc_r;
    logic [2:0]          sv_flags_r;

    logic                rx_take;
    logic                prog_take;
    logic                frame_end;
    logic                tx_step;
    logic                exec;
    logic                irq_num_ok;
    logic [31:0]         alu_a;
    logic [31:0]         alu_b;
    logic [31:0]         res_a;
    logic [31:0]         res_b;
    logic                wr_a;
    logic                wr_b;
    logic                flag_wr;
    logic [2:0]          alu_flags;
    logic                alu_ok;
    logic                calc_ok;
    logic [7:0]          exec_status;
    logic                enter;
    logic [NUM_IRQ-1:0]  take_mask;
    logic [31:0]         enter_vec;

    assign rx_take    = rx_valid && rx_ready;
    assign prog_take  = prog_valid && prog_ready;
    assign frame_end  = rx_take && (cnt_r == `SIVC_FRAME_LAST);
    assign tx_step    = tx_valid && tx_ready;
    assign exec       = (state_r == SIVC_EXEC);
    assign irq_num_ok = (32'(type_r) < NUM_IRQ);
    assign alu_a      = uvar_r[bank_r];
    assign alu_b      = uvar_r[value_r[7:0]];
    assign calc_ok    = alu_ok && (value_r[31:8] == 24'h00_0000);

    sivc_alu u_alu (
        .op_type (type_r),
        .var_a   (alu_a),
        .var_b   (alu_b),
        .res_a   (res_a),
        .res_b   (res_b),
        .wr_a    (wr_a),
        .wr_b    (wr_b),
        .flag_wr (flag_wr),
        .flags   (alu_flags),
        .ok      (alu_ok)
    );

    always_comb begin
        case (op_r)
            `SIVC_OP_IRQ_ENABLE, `SIVC_OP_IRQ_DISABLE:
                exec_status = (irq_num_ok || type_r == `SIVC_IRQ_GLOBAL) ?
                              `SIVC_ST_OK : `SIVC_ST_BAD_VALUE;
            `SIVC_OP_IRQ_VECTOR:
                exec_status = irq_num_ok ? `SIVC_ST_OK : `SIVC_ST_BAD_VALUE;
            `SIVC_OP_IRQ_RETURN:
                exec_status = in_handler ? `SIVC_ST_OK : `SIVC_ST_BAD_CMD;
            `SIVC_OP_TWO_VAR_CALC:
                exec_status = calc_ok ? `SIVC_ST_OK : `SIVC_ST_BAD_VALUE;
            default:
                exec_status = `SIVC_ST_BAD_CMD;
        endcase
    end

    // Lowest pending and enabled source wins
    always_comb begin
        enter     = 1'b0;
        take_mask = '0;
        enter_vec = `SIVC_RST_WORD;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (pend_r[i] && irq_en_r[i]) begin
                take_mask = '0;
                take_mask[i] = 1'b1;
                enter_vec = vec_r[i];
                enter = irq_global_en && !in_handler;
            end
        end
        if (!enter) begin
            take_mask = '0;
        end
    end

    // Frame collection, execution and reply sequencing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r     <= SIVC_IDLE;
            cnt_r       <= 4'h0;
            sum_r       <= `SIVC_RST_BYTE;
            addr_r      <= `SIVC_RST_BYTE;
            op_r        <= `SIVC_RST_BYTE;
            type_r      <= `SIVC_RST_BYTE;
            bank_r      <= `SIVC_RST_BYTE;
            value_r     <= `SIVC_RST_WORD;
            from_host_r <= 1'b0;
            status_r    <= `SIVC_RST_BYTE;
            rx_ready    <= 1'b0;
            prog_ready  <= 1'b0;
            prog_done   <= 1'b0;
            prog_status <= `SIVC_RST_BYTE;
        end else begin
            prog_done <= 1'b0;
            if (rx_take) begin
                cnt_r <= frame_end ? 4'h0 : cnt_r + 4'h1;
                sum_r <= frame_end ? `SIVC_RST_BYTE : sum_r + rx_data;
                case (cnt_r)
                    `SIVC_IDX_ADDR: addr_r <= rx_data;
                    `SIVC_IDX_OP:   op_r   <= rx_data;
                    `SIVC_IDX_TYPE: type_r <= rx_data;
                    `SIVC_IDX_BANK: bank_r <= rx_data;
                    `SIVC_FRAME_LAST: ;
                    default: value_r <= {value_r[23:0], rx_data};
                endcase
            end
            case (state_r)
                SIVC_IDLE: begin
                    if (frame_end && addr_r == MODULE_ADDR) begin
                        from_host_r <= 1'b1;
                        rx_ready    <= 1'b0;
                        prog_ready  <= 1'b0;
                        if (rx_data == sum_r) begin
                            state_r <= SIVC_EXEC;
                        end else begin
                            status_r <= `SIVC_ST_BAD_SUM;
                            state_r  <= SIVC_TX;
                        end
                    end else if (prog_take) begin
                        from_host_r <= 1'b0;
                        op_r        <= prog_op;
                        type_r      <= prog_type;
                        bank_r      <= prog_bank;
                        value_r     <= prog_value;
                        rx_ready    <= 1'b0;
                        prog_ready  <= 1'b0;
                        state_r     <= SIVC_EXEC;
                    end else begin
                        rx_ready   <= 1'b1;
                        // Program waits while a host frame is half received
                        prog_ready <= (cnt_r == 4'h0) && !rx_take;
                    end
                end
                SIVC_EXEC: begin
                    status_r <= exec_status;
                    if (from_host_r) begin
                        state_r <= SIVC_TX;
                    end else begin
                        prog_done   <= 1'b1;
                        prog_status <= exec_status;
                        state_r     <= SIVC_IDLE;
                    end
                end
                SIVC_TX: begin
                    if (tx_step && tx_idx_r == `SIVC_FRAME_LAST) begin
                        state_r <= SIVC_IDLE;
                    end
                end
                default: state_r <= SIVC_IDLE;
            endcase
        end
    end

    // Reply serialiser; value field is always zero
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_data  <= `SIVC_RST_BYTE;
            tx_valid <= 1'b0;
            tx_idx_r <= 4'h0;
            tx_sum_r <= `SIVC_RST_BYTE;
        end else if (exec && from_host_r ||
                     state_r == SIVC_IDLE && frame_end &&
                     addr_r == MODULE_ADDR && rx_data != sum_r) begin
            tx_data  <= HOST_ADDR;
            tx_valid <= 1'b1;
            tx_idx_r <= 4'h0;
            tx_sum_r <= HOST_ADDR;
        end else if (tx_step) begin
            tx_idx_r <= tx_idx_r + 4'h1;
            case (tx_idx_r)
                4'h0: tx_data <= MODULE_ADDR;
                4'h1: tx_data <= status_r;
                4'h2: tx_data <= op_r;
                // Fourth value byte goes out before the checksum
                4'h7: tx_data <= tx_sum_r + op_r + status_r;
                default: tx_data <= `SIVC_RST_BYTE;
            endcase
            case (tx_idx_r)
                4'h0: tx_sum_r <= tx_sum_r + MODULE_ADDR;
                default: ;
            endcase
            if (tx_idx_r == `SIVC_FRAME_LAST) begin
                tx_valid <= 1'b0;
            end
        end
    end

    // User variables; accumulator and X live outside and are never written
    always_ff @(posedge core_clk) begin
        if (rst) begin
            for (int i = 0; i < `SIVC_VAR_COUNT; i++) begin
                uvar_r[i] <= `SIVC_RST_WORD;
            end
        end else if (exec && op_r == `SIVC_OP_TWO_VAR_CALC && calc_ok) begin
            if (wr_b) begin
                uvar_r[value_r[7:0]] <= res_b;
            end
            if (wr_a) begin
                uvar_r[bank_r] <= res_a;
            end
        end
    end

    // Enables, vectors and pending sources
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_global_en <= 1'b0;
            irq_en_r      <= '0;
            pend_r        <= '0;
            for (int i = 0; i < NUM_IRQ; i++) begin
                vec_r[i] <= `SIVC_RST_WORD;
            end
        end else begin
            // A new request in the cycle it is taken stays pending
            pend_r <= (pend_r & ~take_mask) | irq_src;
            if (exec && op_r == `SIVC_OP_IRQ_DISABLE) begin
                if (type_r == `SIVC_IRQ_GLOBAL) begin
                    irq_global_en <= 1'b0;
                end else if (irq_num_ok) begin
                    irq_en_r[type_r[$clog2(NUM_IRQ)-1:0]] <= 1'b0;
                end
            end
            if (exec && op_r == `SIVC_OP_IRQ_ENABLE) begin
                if (type_r == `SIVC_IRQ_GLOBAL) begin
                    irq_global_en <= 1'b1;
                end else if (irq_num_ok) begin
                    irq_en_r[type_r[$clog2(NUM_IRQ)-1:0]] <= 1'b1;
                end
            end
            if (exec && op_r == `SIVC_OP_IRQ_VECTOR && irq_num_ok) begin
                // Plain overwrite, newest address wins
                vec_r[type_r[$clog2(NUM_IRQ)-1:0]] <= value_r;
            end
        end
    end

    // Handler entry and return with context save and restore
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_handler <= 1'b0;
            irq_enter  <= 1'b0;
            irq_vector <= `SIVC_RST_WORD;
            irq_return <= 1'b0;
            ret_accu   <= `SIVC_RST_WORD;
            ret_x      <= `SIVC_RST_WORD;
            ret_pc     <= `SIVC_RST_WORD;
            cond_flags <= 3'h0;
            sv_accu_r  <= `SIVC_RST_WORD;
            sv_x_r     <= `SIVC_RST_WORD;
            sv_pc_r    <= `SIVC_RST_WORD;
            sv_flags_r <= 3'h0;
        end else begin
            irq_enter  <= 1'b0;
            irq_return <= 1'b0;
            if (exec && op_r == `SIVC_OP_TWO_VAR_CALC && calc_ok && flag_wr) begin
                cond_flags <= alu_flags;
            end
            if (enter && !exec) begin
                in_handler <= 1'b1;
                irq_enter  <= 1'b1;
                irq_vector <= enter_vec;
                sv_accu_r  <= ctx_accu;
                sv_x_r     <= ctx_x;
                sv_pc_r    <= ctx_pc;
                sv_flags_r <= cond_flags;
            end else if (exec && op_r == `SIVC_OP_IRQ_RETURN && in_handler) begin
                in_handler <= 1'b0;
                irq_return <= 1'b1;
                ret_accu   <= sv_accu_r;
                ret_x      <= sv_x_r;
                ret_pc     <= sv_pc_r;
                cond_flags <= sv_flags_r;
            end
        end
    end

endmodule : sivc_core

`default_nettype wire

// ### verilog/sivc_map.svh
// Opcodes, status codes, frame layout and reset values of the interpreter
`ifndef SIVC_MAP_SVH
`define SIVC_MAP_SVH

`define SIVC_OP_IRQ_ENABLE   8'h19
`define SIVC_OP_IRQ_DISABLE  8'h1A
`define SIVC_OP_IRQ_VECTOR   8'h25
`define SIVC_OP_IRQ_RETURN   8'h26
`define SIVC_OP_TWO_VAR_CALC 8'h28

`define SIVC_IRQ_GLOBAL      8'hFF

`define SIVC_ST_OK           8'h64
`define SIVC_ST_BAD_SUM      8'h01
`define SIVC_ST_BAD_CMD      8'h02
`define SIVC_ST_BAD_VALUE    8'h04

`define SIVC_FRAME_LAST      4'h8
`define SIVC_IDX_ADDR        4'h0
`define SIVC_IDX_OP          4'h1
`define SIVC_IDX_TYPE        4'h2
`define SIVC_IDX_BANK        4'h3

`define SIVC_VAR_COUNT       256
`define SIVC_FLAG_EQ         0
`define SIVC_FLAG_LT         1
`define SIVC_FLAG_GT         2
`define SIVC_RST_WORD        32'h0000_0000
`define SIVC_RST_BYTE        8'h00

`endif

// ### verilog/sivc_pkg.sv
// Types shared by the interpreter core and its calculation unit
package sivc_pkg;

    typedef enum logic [1:0] {
        SIVC_IDLE = 2'b00,
        SIVC_EXEC = 2'b01,
        SIVC_TX   = 2'b10
    } sivc_state_t;

    typedef enum logic [3:0] {
        CALC_ADD              = 4'h0,
        CALC_SUB              = 4'h1,
        CALC_MUL              = 4'h2,
        CALC_DIV              = 4'h3,
        CALC_MODULO_OPERATION = 4'h4,
        CALC_AND              = 4'h5,
        CALC_OR               = 4'h6,
        CALC_XOR              = 4'h7,
        CALC_NOT              = 4'h8,
        CALC_LOAD             = 4'h9,
        CALC_SWAP             = 4'hA,
        CALC_COMP             = 4'hB
    } sivc_calc_t;

endpackage : sivc_pkg

// ### verilog/sivc_alu.sv
// Combinational two-variable calculation unit
`timescale 1ns/1ns
`default_nettype none
`include "sivc_map.svh"

module sivc_alu (
    // Operation and operands
    input  wire logic [7:0]  op_type,
    input  wire logic [31:0] var_a,
    input  wire logic [31:0] var_b,
    // Results
    output logic      [31:0] res_a,
    output logic      [31:0] res_b,
    output logic             wr_a,
    output logic             wr_b,
    output logic             flag_wr,
    output logic      [2:0]  flags,
    output logic             ok
);
    import sivc_pkg::*;

    always_comb begin
        res_a   = var_a;
        res_b   = var_b;
        wr_a    = 1'b1;
        wr_b    = 1'b0;
        flag_wr = 1'b0;
        flags   = 3'h0;
        ok      = 1'b1;
        if (op_type[7:4] != 4'h0) begin
            wr_a = 1'b0;
            ok   = 1'b0;
        end else begin
            case (sivc_calc_t'(op_type[3:0]))
                CALC_ADD: res_a = var_a + var_b;
                CALC_SUB: res_a = var_a - var_b;
                CALC_MUL: res_a = 32'(var_a * var_b);
                CALC_DIV, CALC_MODULO_OPERATION: begin
                    // Zero divisor leaves the variable untouched
                    if (var_b == 32'h0000_0000) begin
                        wr_a = 1'b0;
                        ok   = 1'b0;
                    end else if (op_type[3:0] == 4'h3) begin
                        res_a = 32'($signed(var_a) / $signed(var_b));
                    end else begin
                        res_a = 32'($signed(var_a) % $signed(var_b));
                    end
                end
                CALC_AND:  res_a = var_a & var_b;
                CALC_OR:   res_a = var_a | var_b;
                CALC_XOR:  res_a = var_a ^ var_b;
                CALC_NOT:  res_a = ~var_b;
                CALC_LOAD: res_a = var_b;
                CALC_SWAP: begin
                    res_a = var_b;
                    res_b = var_a;
                    wr_b  = 1'b1;
                end
                CALC_COMP: begin
                    wr_a    = 1'b0;
                    flag_wr = 1'b1;
                    flags[`SIVC_FLAG_EQ] = (var_a == var_b);
                    flags[`SIVC_FLAG_LT] = ($signed(var_a) < $signed(var_b));
                    flags[`SIVC_FLAG_GT] = ($signed(var_a) > $signed(var_b));
                end
                default: begin
                    wr_a = 1'b0;
                    ok   = 1'b0;
                end
            endcase
        end
    end

endmodule : sivc_alu

`default_nettype wire

// ### verification/sivc_props.sv
// Port assertions for the interpreter core
`timescale 1ns/1ns
`default_nettype none
module sivc_props #(
    parameter logic [7:0] HOST_ADDR = 8'h02
) (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // Host link
    input wire logic       rx_ready,
    input wire logic [7:0] tx_data,
    input wire logic       tx_valid,
    input wire logic       tx_ready,
    // Program port
    input wire logic       prog_valid,
    input wire logic       prog_ready,
    input wire logic       prog_done,
    // Interrupt state
    input wire logic       irq_enter,
    input wire logic       irq_return,
    input wire logic       irq_global_en,
    input wire logic       in_handler
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        prog_valid && prog_ready;
    endsequence
    sequence s_stall;
        tx_valid && !tx_ready;
    endsequence
    chk_prog_answer: assert property (s_take |=> !prog_done ##1 prog_done)
        else $error("program answer not two cycles after take");
    chk_done_pulse: assert property (prog_done |=> !prog_done)
        else $error("done pulse longer than one cycle");
    chk_enter_state: assert property (irq_enter |-> in_handler && !$past(in_handler))
        else $error("handler entry without clean state change");
    chk_enter_global: assert property (irq_enter |-> $past(irq_global_en))
        else $error("handler entered while globally disabled");
    chk_return_inside: assert property (irq_return |-> $past(in_handler))
        else $error("return outside a handler");
    chk_reply_lock: assert property (tx_valid |-> !rx_ready)
        else $error("command byte accepted during reply");
    chk_tx_hold: assert property (s_stall |=> tx_valid && $stable(tx_data))
        else $error("reply byte changed while stalled");
    chk_reply_head: assert property ($rose(tx_valid) |-> tx_data == HOST_ADDR)
        else $error("reply does not open with host address");
endmodule : sivc_props
bind sivc_core sivc_props #(.HOST_ADDR(HOST_ADDR)) u_props (
    .core_clk(core_clk), .rst(rst), .rx_ready(rx_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_done(prog_done), .irq_enter(irq_enter),
    .irq_return(irq_return), .irq_global_en(irq_global_en),
    .in_handler(in_handler)
);
`default_nettype wire

// ### verification/sivc_host.sv
// Host model: sends command frames, sinks reply bytes with random stalls
`timescale 1ns/1ns
`default_nettype none
module sivc_host (
    // Clock
    input wire logic        core_clk,
    // Command bytes
    output var logic  [7:0] rx_data,
    output var logic        rx_valid,
    input wire logic        rx_ready,
    // Reply bytes
    output var logic        tx_ready
);
    int seed = 32'h0491;
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    always @(negedge core_clk) begin
        tx_ready <= ($random(seed) & 3) != 0;
    end
    task automatic send(input logic [63:0] f, input logic bad);
        logic [7:0] b [9];
        logic [7:0] sum;
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            b[i] = f[63-8*i -: 8];
            sum = sum + b[i];
        end
        b[8] = bad ? ~sum : sum;
        for (int i = 0; i < 9; i++) begin
            @(negedge core_clk);
            while (!rx_ready) @(negedge core_clk);
            rx_data = b[i];
            rx_valid = 1'b1;
        end
        @(negedge core_clk);
        rx_valid = 1'b0;
        // Released line must not keep showing the last byte
        rx_data = ~rx_data;
    endtask : send
endmodule : sivc_host
`default_nettype wire

// ### verification/tb_sivc_core.sv
// Self-checking bench for the interpreter core
`timescale 1ns/1ns
`default_nettype none
module tb_sivc_core;
    logic               core_clk, rst, rx_valid, rx_ready, tx_valid, tx_ready;
    logic         [7:0] rx_data, tx_data, prog_op, prog_type, prog_bank;
    logic         [7:0] prog_status, irq_src;
    logic               prog_valid, prog_ready, prog_done, irq_enter;
    logic               irq_return, irq_global_en, in_handler;
    logic        [31:0] prog_value, ctx_accu, ctx_x, ctx_pc, irq_vector;
    logic        [31:0] ret_accu, ret_x, ret_pc;
    logic         [2:0] cond_flags;
    logic signed [31:0] m [4];
    logic        [31:0] q_tx [$], q_st [$], q_iv [$], q_rt [$];
    logic        [11:0] s;
    int                 mismatches = 0, n_checks = 0, seed = 32'h0491;

    sivc_core uut (
        .core_clk(core_clk), .rst(rst), .rx_data(rx_data),
        .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .prog_valid(prog_valid),
        .prog_op(prog_op), .prog_type(prog_type), .prog_bank(prog_bank),
        .prog_value(prog_value), .prog_ready(prog_ready),
        .prog_done(prog_done), .prog_status(prog_status), .irq_src(irq_src),
        .ctx_accu(ctx_accu), .ctx_x(ctx_x), .ctx_pc(ctx_pc),
        .irq_enter(irq_enter), .irq_vector(irq_vector),
        .irq_return(irq_return), .ret_accu(ret_accu), .ret_x(ret_x),
        .ret_pc(ret_pc), .cond_flags(cond_flags),
        .irq_global_en(irq_global_en), .in_handler(in_handler)
    );
    sivc_host host (
        .core_clk(core_clk), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .tx_ready(tx_ready)
    );

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic stop_test;
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    task automatic reply(input logic [7:0] op, st);
        q_tx.push_back(8'h02);
        q_tx.push_back(8'h01);
        q_tx.push_back(st);
        q_tx.push_back(op);
        repeat (4) q_tx.push_back(8'h00);
        q_tx.push_back(8'(8'h03 + st + op));
    endtask : reply
    task automatic prog(input logic [7:0] op, t, bk, input logic [31:0] v,
                        input logic [7:0] st);
        @(negedge core_clk);
        while (!prog_ready) @(negedge core_clk);
        prog_op = op;
        prog_type = t;
        prog_bank = bk;
        prog_value = v;
        prog_valid = 1'b1;
        q_st.push_back(st);
        @(negedge core_clk);
        prog_valid = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : prog
    // Reference model of four user variables
    function automatic logic [7:0] calc(input logic [3:0] t, input int a, b);
        logic signed [31:0] x, y;
        x = m[a];
        y = m[b];
        if (t inside {4'h3, 4'h4} && y == 0) return 8'h04;
        case (t)
            4'h0: m[a] = x + y;
            4'h1: m[a] = x - y;
            4'h2: m[a] = x * y;
            4'h3: m[a] = x / y;
            4'h4: m[a] = x % y;
            4'h5: m[a] = x & y;
            4'h6: m[a] = x | y;
            4'h7: m[a] = x ^ y;
            4'h8: m[a] = ~y;
            4'h9: m[a] = y;
            4'hA: begin
                m[a] = y;
                m[b] = x;
            end
            default: ;
        endcase
        return 8'h64;
    endfunction : calc

    always @(posedge core_clk) begin
        if (tx_valid && tx_ready) chk("reply", q_tx.pop_front(), tx_data);
        if (prog_done) chk("status", q_st.pop_front(), prog_status);
        if (irq_enter) chk("vector", q_iv.pop_front(), irq_vector);
        if (irq_return) chk("return pc", q_rt.pop_front(), ret_pc);
    end
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // About 300 cycles are needed; allow ample margin
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
    initial begin
        {rst, prog_valid, prog_op, prog_type, prog_bank, irq_src} = 34'h200000000;
        {prog_value, ctx_accu, ctx_x, ctx_pc} = 128'h0;
        foreach (m[i]) m[i] = 32'sh0;
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        chk("global after reset", 0, irq_global_en);
        for (int i = 0; i < 18; i++) begin
            s = (i < 5) ? 12'h830 >> 0 : 12'h0;
            case (i)
                0: s = 12'h830;
                1: s = 12'h113;
                2, 3: s = 12'h011;
                4: s = 12'h023;
                17: s = 12'h320;
                default: s = {4'(i - 5), 8'h21};
            endcase
            prog(8'h28, {4'h0, s[11:8]}, {4'h0, s[7:4]}, {28'h0, s[3:0]},
                 calc(s[11:8], s[7:4], s[3:0]));
            prog(8'h28, 8'h0B, {4'h0, s[7:4]}, {28'h0, s[3:0]}, 8'h64);
            chk("flags", {m[s[7:4]] > m[s[3:0]], m[s[7:4]] < m[s[3:0]],
                m[s[7:4]] == m[s[3:0]]}, cond_flags);
        end
        prog(8'h25, 8'h03, 8'h00, 32'h50, 8'h64);
        prog(8'h25, 8'h03, 8'h00, 32'h60, 8'h64);
        prog(8'h19, 8'h03, 8'h00, 32'h0, 8'h64);
        prog(8'h19, 8'hFF, 8'h00, 32'h0, 8'h64);
        chk("global on", 1, irq_global_en);
        ctx_accu = $random(seed);
        ctx_x = $random(seed);
        ctx_pc = $random(seed);
        q_iv.push_back(32'h60);
        irq_src = 8'h08;
        @(negedge core_clk);
        irq_src = 8'h00;
        repeat (4) @(negedge core_clk);
        chk("in handler", 1, in_handler);
        q_rt.push_back(ctx_pc);
        prog(8'h26, 8'hFF, 8'h00, 32'h0, 8'h64);
        chk("accu", ctx_accu, ret_accu);
        chk("x", ctx_x, ret_x);
        chk("pc", ctx_pc, ret_pc);
        chk("out of handler", 0, in_handler);
        prog(8'h26, 8'hFF, 8'h00, 32'h0, 8'h02);
        prog(8'h1A, 8'h03, 8'h55, 32'hFFFF, 8'h64);
        irq_src = 8'h08;
        repeat (6) @(negedge core_clk);
        irq_src = 8'h00;
        reply(8'h28, 8'h64);
        host.send(64'h01_28_01_41_0000_002A, 1'b0);
        reply(8'h1A, 8'h01);
        host.send(64'h01_1A_FF_00_0000_0000, 1'b1);
        host.send(64'h05_1A_FF_00_0000_0000, 1'b0);
        reply(8'h28, 8'h04);
        host.send(64'h01_28_00_00_0000_0100, 1'b0);
        reply(8'h1A, 8'h64);
        host.send(64'h01_1A_FF_00_0000_0000, 1'b0);
        for (int k = 0; k < 200 && q_tx.size() != 0; k++) @(negedge core_clk);
        repeat (4) @(negedge core_clk);
        chk("global off", 0, irq_global_en);
        chk("pending notes", 0,
            q_tx.size() + q_st.size() + q_iv.size() + q_rt.size());
        stop_test();
    end
endmodule : tb_sivc_core
`default_nettype wire
